// *** gtc_threshold_core.sv ***
// Threshold, learning, self-discharge and taper decisions of the gauge
// Notes on behaviour
// (RULE1) Empty byte means mV/8 minus 256
// (RULE2) Learn byte: 6.25% remaining, same scaling
// (RULE3) Learn threshold in valid discharge updates capacity
// (RULE4) Current at most twice standby disqualifies learning
// (RULE5) Standby byte counts 6 uV on sense
// (RULE6) Upper nibble deadband, lower nibble self-discharge code
// (RULE7) No self-discharge while charging
// (RULE8) Programmed rate in 20 to 30 C
// (RULE9) Double per hotter band, max 16x
// (RULE10) Halve per colder band, min quarter
// (RULE11) Each step removes capacity divided by 512
// (RULE12) Code 12 gives 24 hour interval
// (RULE13) Full charge uses voltage and taper byte
// (RULE14) Taper flag on low current, high voltage
// (RULE15) Empty threshold in discharge clears capacity
// (RULE16) Learn flag rise with valid discharge updates
// (RULE17) Compare voltage as (byte+256)*8 unsigned
`timescale 1ns/1ps
`default_nettype none
module gtc_threshold_core import gtc_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter logic [15:0] INIT_LMD = 16'h0000,
  parameter logic [8*CFG_COUNT-1:0] CFG_INIT = '0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic regWrEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic [15:0] battMv,
  input wire logic signed [15:0] avgCur,
  input wire logic charging,
  input wire logic countPulse,
  input wire logic countDir,
  input wire logic signed [7:0] tempC,
  input wire logic [1:0] termVoltSel,
  output logic [15:0] nominalAvailableCapacity,
  output logic [15:0] learnedFullCapacity,
  output logic chargeTaperFlag,
  output logic lowVoltageLearnFlag,
  output logic emptyVoltageFlag,
  output logic validDischargeFlag,
  output logic noActivityFlag
);
  // Rebuild millivolts from a scaled threshold byte
  function automatic logic [15:0] voltFromByte(input logic [7:0] b);
    return (16'(b) + VOLT_OFFSET) << VOLT_SHIFT; // [RULE1] [RULE2] [RULE17]
  endfunction

  // Magnitude of a signed current
  function automatic logic [15:0] mag(input logic signed [15:0] v);
    return v[15] ? 16'(-v) : 16'(v);
  endfunction

  // Rate weight from temperature band, reference band weighs 4
  function automatic logic [6:0] sdWeightOf(input logic signed [7:0] t);
    if (t >= T_60) return SD_W_MAX; // [RULE9]
    else if (t >= T_50) return SD_W_X8;
    else if (t >= T_40) return SD_W_X4;
    else if (t >= T_30) return SD_W_X2;
    else if (t >= T_20) return SD_W_REF; // [RULE8]
    else if (t >= T_10) return SD_W_HALF; // [RULE10]
    else return SD_W_MIN; // [RULE10]
  endfunction

  // Capacity including the remaining sixteenth: d + d/15
  function automatic logic [15:0] learnedCap(input logic [15:0] d);
    logic [16:0] s;
    s = 17'(d) + 17'(17'(d) / LEARN_DIV);
    return s[16] ? 16'hffff : s[15:0];
  endfunction

  // Configuration access
  logic [7:0] cfgOff; // Address relative to first byte
  logic cfgHit; // Address falls on a configuration byte
  logic [8*CFG_COUNT-1:0] cfgFlat;
  logic [7:0] emptyByte, learnByte, standbyByte, filterByte, taperByte;
  assign cfgOff = regAddr - ADDR_EMPTY_VOLT;
  assign cfgHit = (regAddr >= ADDR_EMPTY_VOLT) && (regAddr <= ADDR_TAPER);
  assign emptyByte = cfgFlat[8*(ADDR_EMPTY_VOLT - ADDR_EMPTY_VOLT) +: 8];
  assign learnByte = cfgFlat[8*(ADDR_LEARN_VOLT - ADDR_EMPTY_VOLT) +: 8];
  assign standbyByte = cfgFlat[8*(ADDR_STANDBY - ADDR_EMPTY_VOLT) +: 8];
  assign filterByte = cfgFlat[8*(ADDR_FILTER_SD - ADDR_EMPTY_VOLT) +: 8];
  assign taperByte = cfgFlat[8*(ADDR_TAPER - ADDR_EMPTY_VOLT) +: 8];

  // Byte store; read data leaves from its register
  gtc_cfg_mem #(.DW(8), .N(CFG_COUNT), .INIT(CFG_INIT)) uMem (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .wrEn(regWrEn),
    .hit(cfgHit),
    .idx(cfgOff[CFG_IDX_W-1:0]),
    .wrData(regWrData),
    .rdData(regRdData),
    .cfgFlat(cfgFlat)
  );

  // Decoded thresholds and derived quantities
  logic [15:0] emptyMv, learnMv, termMv, curMag, taperLim, standbyLim;
  logic [3:0] deadband, sdCode;
  logic [6:0] sdWeight;
  logic [23:0] sdTarget;
  always_comb begin
    emptyMv = voltFromByte(emptyByte); // [RULE1]
    learnMv = voltFromByte(learnByte); // [RULE2]
    deadband = filterByte[DEADBAND_MSB:DEADBAND_LSB]; // [RULE6]
    sdCode = filterByte[SD_CODE_MSB:SD_CODE_LSB]; // [RULE6]
    curMag = mag(avgCur);
    taperLim = 16'(taperByte) << TAPER_SHIFT; // [RULE13]
    standbyLim = 16'(standbyByte) << STANDBY_SHIFT; // [RULE5]
    sdWeight = sdWeightOf(tempC);
    // Interval in seconds at reference is code * 2 h, so 12 gives 24 h
    sdTarget = 24'(24'(sdCode) * SD_UNIT_S * SD_REF_WEIGHT); // [RULE12]
    unique case (termVoltSel)
      2'b00: termMv = TERM_MV_0;
      2'b01: termMv = TERM_MV_1;
      2'b10: termMv = TERM_MV_2;
      2'b11: termMv = TERM_MV_3;
    endcase
  end

  // State of the gauge
  logic [31:0] tickCnt, next_tickCnt; // One-second prescaler
  logic [23:0] sdAcc, next_sdAcc; // Weighted seconds since last step
  logic [15:0] dischargedCnt, next_dischargedCnt; // Counted since full
  logic [15:0] next_nac, next_lmd;
  logic next_taper, next_lowVolt, next_empty, next_vdq, next_noAct;
  logic tick, countOk, sdStep, atEmpty, learnRise, disqualify, learnFire;
  logic [23:0] sdSum;

  // Next-state computation for all gauge state
  always_comb begin
    tick = (tickCnt == 32'(TICK_CYCLES - 1));
    next_tickCnt = tick ? '0 : tickCnt + 32'h00000001;
    // Counts below the deadband are treated as noise
    countOk = countPulse && (curMag >= 16'(deadband)); // [RULE6]
    next_noAct = (curMag < 16'(deadband));
    // Self-discharge only accrues out of charge; a zero code disables it
    sdSum = sdAcc + 24'(sdWeight);
    sdStep = 1'b0;
    next_sdAcc = sdAcc;
    if (charging || (sdCode == '0)) begin
      next_sdAcc = '0; // [RULE7]
    end else if (tick) begin
      if (sdSum >= sdTarget) begin
        sdStep = 1'b1; // [RULE9] [RULE10] [RULE12]
        next_sdAcc = '0;
      end else begin
        next_sdAcc = sdSum;
      end
    end
    atEmpty = !charging && (battMv <= emptyMv); // [RULE15] [RULE17]
    // Capacity: counting, then self-discharge, then empty clear wins
    next_nac = nominalAvailableCapacity;
    if (countOk) begin
      if (countDir) begin
        next_nac = (next_nac == 16'hffff) ? next_nac : next_nac + 16'h0001;
      end else begin
        next_nac = (next_nac == '0) ? next_nac : next_nac - 16'h0001;
      end
    end
    if (sdStep) begin
      next_nac = next_nac - (next_nac >> SD_DIV_SHIFT); // [RULE11]
    end
    if (atEmpty) begin
      next_nac = '0; // [RULE15]
    end
    // Flags that fall when charging starts
    next_empty = atEmpty;
    next_lowVolt = !charging && (battMv <= learnMv); // [RULE2] [RULE17]
    // Full charge: low taper current at or above termination voltage
    next_taper = charging && !avgCur[15] && (curMag < taperLim)
                 && (battMv >= termMv); // [RULE13] [RULE14]
    // Learning on the rising edge of the low-voltage flag
    learnRise = next_lowVolt && !lowVoltageLearnFlag;
    disqualify = curMag <= standbyLim; // [RULE4]
    learnFire = learnRise && validDischargeFlag && !disqualify; // [RULE3] [RULE16]
    next_lmd = learnFire ? learnedCap(dischargedCnt) : learnedFullCapacity; // [RULE3]
    next_vdq = validDischargeFlag;
    next_dischargedCnt = dischargedCnt;
    if (learnRise && validDischargeFlag) begin
      next_vdq = 1'b0; // [RULE4] [RULE16]
    end else if (countOk && !countDir && validDischargeFlag) begin
      next_dischargedCnt = dischargedCnt + 16'h0001;
    end
    // Reaching full starts a fresh qualified discharge
    if (next_taper && !chargeTaperFlag) begin
      next_vdq = 1'b1;
      next_dischargedCnt = '0;
    end
  end

  // Registers; the clock enable freezes everything
  always_ff @(posedge clk) begin
    if (srst) begin
      tickCnt <= '0;
      sdAcc <= '0;
      dischargedCnt <= '0;
      nominalAvailableCapacity <= '0;
      learnedFullCapacity <= INIT_LMD;
      chargeTaperFlag <= 1'b0; // [RULE14]
      lowVoltageLearnFlag <= 1'b0;
      emptyVoltageFlag <= 1'b0;
      validDischargeFlag <= 1'b0;
      noActivityFlag <= 1'b0;
    end else if (ce) begin
      tickCnt <= next_tickCnt;
      sdAcc <= next_sdAcc;
      dischargedCnt <= next_dischargedCnt;
      nominalAvailableCapacity <= next_nac;
      learnedFullCapacity <= next_lmd;
      chargeTaperFlag <= next_taper;
      lowVoltageLearnFlag <= next_lowVolt;
      emptyVoltageFlag <= next_empty;
      validDischargeFlag <= next_vdq;
      noActivityFlag <= next_noAct;
    end
  end

  // Checks on the decisions above
  AST_EMPTY_CLEARS: assert property (@(posedge clk) disable iff (srst) // [RULE15]
    ce && !charging && battMv <= (({8'h00, emptyByte} + 16'h0100) << 3) |=> nominalAvailableCapacity == '0)
    else $error("capacity not cleared at empty threshold");
  AST_NO_SD_CHARGING: assert property (@(posedge clk) disable iff (srst) // [RULE7]
    ce && charging && !countPulse |=> $stable(nominalAvailableCapacity))
    else $error("capacity moved while charging without counts");
  AST_SD_STEP: assert property (@(posedge clk) disable iff (srst) // [RULE11]
    ce && sdStep && !countOk && !atEmpty
    |=> nominalAvailableCapacity == $past(nominalAvailableCapacity) - ($past(nominalAvailableCapacity) >> 9))
    else $error("self-discharge step not capacity/512");
  AST_TAPER_SET: assert property (@(posedge clk) disable iff (srst) // [RULE14]
    ce && charging && !avgCur[15] && curMag < ({8'h00, taperByte} << 5) && battMv >= termMv
    |=> chargeTaperFlag)
    else $error("taper flag not set");
  AST_TAPER_RESET: assert property (@(posedge clk) // [RULE14]
    srst |=> !chargeTaperFlag)
    else $error("taper flag survived reset");
  AST_LEARN_FLAG: assert property (@(posedge clk) disable iff (srst) // [RULE2]
    ce && !charging && battMv <= (({8'h00, learnByte} + 16'h0100) << 3) |=> lowVoltageLearnFlag)
    else $error("low-voltage learn flag not set");
  AST_LEARN_UPDATE: assert property (@(posedge clk) disable iff (srst) // [RULE16]
    ce && learnRise && validDischargeFlag && curMag > ({8'h00, standbyByte} << 1)
    |=> learnedFullCapacity == learnedCap($past(dischargedCnt)) && !validDischargeFlag)
    else $error("learned capacity not updated");
  AST_DISQUALIFY: assert property (@(posedge clk) disable iff (srst) // [RULE4]
    ce && learnRise && validDischargeFlag && curMag <= ({8'h00, standbyByte} << 1)
    |=> $stable(learnedFullCapacity) && !validDischargeFlag)
    else $error("low-current learning not disqualified");
  AST_HOT_CAP: assert property (@(posedge clk) disable iff (srst) // [RULE9]
    tempC >= 8'sd60 |-> sdWeight == 7'h40)
    else $error("hot weight not 16x");
  AST_COLD_FLOOR: assert property (@(posedge clk) disable iff (srst) // [RULE10]
    tempC < 8'sd10 |-> sdWeight == 7'h01)
    else $error("cold weight not quarter");
  AST_REF_BAND: assert property (@(posedge clk) disable iff (srst) // [RULE8]
    tempC >= 8'sd20 && tempC < 8'sd30 |-> sdWeight == 7'h04)
    else $error("reference band weight wrong");
endmodule
`default_nettype wire

// *** gtc_pkg.sv ***
// Constants shared by the gauge threshold configuration block
`default_nettype none
package gtc_pkg;
  // Configuration byte addresses
  localparam logic [7:0] ADDR_EMPTY_VOLT = 8'h77; // empty_voltage_threshold
  localparam logic [7:0] ADDR_LEARN_VOLT = 8'h78; // learn_voltage_threshold
  localparam logic [7:0] ADDR_STANDBY = 8'h79; // standby_load_current
  localparam logic [7:0] ADDR_FILTER_SD = 8'h7a; // filter_and_self_discharge
  localparam logic [7:0] ADDR_TAPER = 8'h7b; // full_charge_current_threshold
  localparam int CFG_COUNT = 5; // Number of configuration bytes
  localparam int CFG_IDX_W = 3; // Index width for the byte store
  // Field layout of filter_and_self_discharge
  localparam int DEADBAND_MSB = 7;
  localparam int DEADBAND_LSB = 4;
  localparam int SD_CODE_MSB = 3;
  localparam int SD_CODE_LSB = 0;
  // Voltage threshold scaling: mV = (byte + 256) * 8
  localparam logic [15:0] VOLT_OFFSET = 16'h0100;
  localparam int VOLT_SHIFT = 3;
  // Current scaling, all in 6 uV counts
  localparam int TAPER_SHIFT = 5; // 192 uV per count = 32 x 6 uV
  localparam int STANDBY_SHIFT = 1; // Disqualify at twice the standby load
  // Self-discharge
  localparam int SD_DIV_SHIFT = 9; // Each step removes capacity / 512
  localparam logic [23:0] SD_UNIT_S = 24'h001c20; // 7200 s = 2 h per code step
  localparam logic [23:0] SD_REF_WEIGHT = 24'h000004; // Weight in 20..30 C band
  localparam logic [6:0] SD_W_MIN = 7'h01; // Quarter rate
  localparam logic [6:0] SD_W_HALF = 7'h02;
  localparam logic [6:0] SD_W_REF = 7'h04;
  localparam logic [6:0] SD_W_X2 = 7'h08;
  localparam logic [6:0] SD_W_X4 = 7'h10;
  localparam logic [6:0] SD_W_X8 = 7'h20;
  localparam logic [6:0] SD_W_MAX = 7'h40; // 16 times the reference
  // Temperature band edges in degrees C
  localparam logic signed [7:0] T_60 = 8'sh3c;
  localparam logic signed [7:0] T_50 = 8'sh32;
  localparam logic signed [7:0] T_40 = 8'sh28;
  localparam logic signed [7:0] T_30 = 8'sh1e;
  localparam logic signed [7:0] T_20 = 8'sh14;
  localparam logic signed [7:0] T_10 = 8'sh0a;
  // Charge termination voltages in mV, by select code
  localparam logic [15:0] TERM_MV_0 = 16'h0f80; // 3968
  localparam logic [15:0] TERM_MV_1 = 16'h0fb0; // 4016
  localparam logic [15:0] TERM_MV_2 = 16'h0fe0; // 4064
  localparam logic [15:0] TERM_MV_3 = 16'h1010; // 4112
  // Learning: remaining 1/16 added back, d * 16 / 15
  localparam logic [16:0] LEARN_DIV = 17'h0000f;
  // Time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int SEC_NS = 1000000000;
  localparam int TICK_CYCLES_DEF = SEC_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// *** gtc_cfg_mem.sv ***
// Store of the configuration bytes with a registered read port
`timescale 1ns/1ps
`default_nettype none
module gtc_cfg_mem import gtc_pkg::*; #(
  parameter int DW = 8,
  parameter int N = CFG_COUNT,
  parameter logic [8*CFG_COUNT-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic wrEn,
  input wire logic hit,
  input wire logic [CFG_IDX_W-1:0] idx,
  input wire logic [DW-1:0] wrData,
  output logic [DW-1:0] rdData,
  output logic [DW*N-1:0] cfgFlat
);
  // Byte array and read register
  logic [DW-1:0] mem [N];
  logic [DW-1:0] next_rdData;
  logic [DW-1:0] next_mem [N];

  // Next values: write goes in, read of an unmapped address gives zero
  always_comb begin
    for (int i = 0; i < N; i++) begin
      next_mem[i] = mem[i];
    end
    next_rdData = '0;
    if (hit) begin
      next_rdData = mem[idx];
      if (wrEn) begin
        next_mem[idx] = wrData;
      end
    end
  end

  // Registers; reset loads the defaults standing in for stored contents
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < N; i++) begin
        mem[i] <= INIT[i*DW +: DW];
      end
      rdData <= '0;
    end else if (ce) begin
      mem <= next_mem;
      rdData <= next_rdData;
    end
  end

  // Flat view for the decision logic
  always_comb begin
    for (int i = 0; i < N; i++) begin
      cfgFlat[i*DW +: DW] = mem[i];
    end
  end
endmodule
`default_nettype wire

// *** gtc_host_model.sv ***
// Host side model that writes and reads the configuration bytes
`timescale 1ns/1ps
`default_nettype none
module gtc_host_model (
  input wire logic clk,
  output logic regWrEn,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData
);
  // Bus idle at time zero
  initial begin
    regWrEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end
  // One byte write, held for exactly one edge so it lands once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask
  // Present a read address; data follows one edge later
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
  endtask
endmodule
`default_nettype wire

// *** gtc_threshold_core_tb_top.sv ***
// Self-checking bench for the gauge threshold core
`timescale 1ns/1ps
`default_nettype none
module gtc_threshold_core_tb_top import gtc_pkg::*; ();
  localparam logic [7:0] EMPTY_B = 8'h40; // Empty threshold byte
  localparam logic [7:0] LEARN_B = 8'h50; // Learn threshold byte
  localparam logic [15:0] EMPTY_MV = ({8'h00, EMPTY_B} + 16'h0100) * 16'h0008;
  localparam logic [15:0] LEARN_MV = ({8'h00, LEARN_B} + 16'h0100) * 16'h0008;
  typedef struct {logic [1:0] k; logic [15:0] v;} gtc_note_s;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic charging = 1'b0;
  logic countPulse = 1'b0;
  logic countDir = 1'b0;
  logic chkTog = 1'b0; // Flips once per noted result
  logic lastTog = 1'b0;
  logic [15:0] battMv = 16'h0ed8;
  logic signed [15:0] avgCur = 16'sh0000;
  logic signed [7:0] tempC = 8'sh19;
  logic [1:0] termVoltSel = 2'h0;
  logic regWrEn, fTaper, fLearn, fEmpty, fVdq, fIdle;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [15:0] nominal_available_capacity, learned_full_capacity, nacExp, lmdExp, seen;
  logic [4:0] flags;
  logic [7:0] cfgExp [5];
  logic [15:0] termMv [4] = '{TERM_MV_0, TERM_MV_1, TERM_MV_2, TERM_MV_3};
  string kName [4] = '{"regRdData", "capacity", "learned", "flags"};
  gtc_note_s notes [$]; // Expected results, oldest first
  gtc_note_s note;
  integer seed = 32'h0bf6ebe6;
  int d;
  int nMismatch = 0;
  int checksDone = 0;
  assign flags = {fTaper, fLearn, fEmpty, fVdq, fIdle};
  // Free running 100 MHz clock
  always #5 clk = ~clk;
  gtc_host_model host_u (.clk(clk), .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData));
  // Short tick so self-discharge intervals fit the run
  gtc_threshold_core #(.TICK_CYCLES(4), .INIT_LMD(16'h0123)) dut_u (
    .clk(clk), .srst(srst), .ce(ce), .regWrEn(regWrEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .battMv(battMv), .avgCur(avgCur),
    .charging(charging), .countPulse(countPulse), .countDir(countDir), .tempC(tempC),
    .termVoltSel(termVoltSel), .nominalAvailableCapacity(nominal_available_capacity), .learnedFullCapacity(learned_full_capacity),
    .chargeTaperFlag(fTaper), .lowVoltageLearnFlag(fLearn), .emptyVoltageFlag(fEmpty),
    .validDischargeFlag(fVdq), .noActivityFlag(fIdle));
  // Monitor: takes the oldest note whenever a result is flagged
  always @(posedge clk) begin
    if (chkTog !== lastTog) begin
      lastTog = chkTog;
      note = notes.pop_front();
      case (note.k)
        2'h0: seen = {8'h00, regRdData};
        2'h1: seen = nominal_available_capacity;
        2'h2: seen = learned_full_capacity;
        default: seen = {11'h000, flags};
      endcase
      checksDone++;
      if (seen !== note.v) begin
        nMismatch++;
        $display("BAD %s expected %h seen %h", kName[note.k], note.v, seen);
      end
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Note a result; it is sampled at the next edge, before updates
  task automatic chk(input logic [1:0] k, input logic [15:0] v);
    notes.push_back('{k, v});
    chkTog <= ~chkTog;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] v);
    host_u.rd(a);
    @(posedge clk);
    chk(2'h0, {8'h00, v});
  endtask
  // Set measurements and let flags settle
  task automatic meas(input logic [15:0] mv, input logic signed [15:0] cur, input logic chg);
    @(posedge clk);
    battMv <= mv;
    avgCur <= cur;
    charging <= chg;
    step(2);
  endtask
  // Spaced one-cycle count pulses
  task automatic pulses(input int n, input logic dir);
    repeat (n) begin
      @(posedge clk);
      countPulse <= 1'b1;
      countDir <= dir;
      @(posedge clk);
      countPulse <= 1'b0;
    end
    step(2);
  endtask
  // One band: charging clears the accumulator, then chg held for about cyc cycles, one step expected if hit
  task automatic sd_band(input logic signed [7:0] t, input int cyc, input logic chg, input logic hit);
    @(posedge clk);
    charging <= 1'b1;
    tempC <= t;
    step(3);
    charging <= chg;
    step(cyc - 10);
    chk(2'h1, nacExp);
    step(17);
    // Margin covers tick phase and register latency
    if (hit) begin
      nacExp = nacExp - (nacExp >> 9);
    end
    chk(2'h1, nacExp);
  endtask
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Hang guard at 99000 cycles, set above the cycle budget of the whole run
  initial begin
    #990000;
    nMismatch++;
    close_out();
  end
  initial begin
    step(12);
    srst <= 1'b0;
    step(1);
    chk(2'h3, 16'h0000);
    chk(2'h2, 16'h0123);
    for (int i = 0; i < 5; i++) begin
      rdc(8'h77 + 8'(i), 8'h00);
    end
    // Random bytes, unmapped writes, and a write with ce low
    for (int i = 0; i < 5; i++) begin
      cfgExp[i] = 8'($random(seed));
      host_u.wr(8'h77 + 8'(i), cfgExp[i]);
    end
    host_u.wr(8'h76, 8'hff);
    host_u.wr(8'h7c, 8'hff);
    @(posedge clk);
    ce <= 1'b0;
    host_u.wr(8'h77, ~cfgExp[0]);
    ce <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rdc(8'h77 + 8'(i), cfgExp[i]);
    end
    rdc(8'h76, 8'h00);
    rdc(8'h7c, 8'h00);
    tdone("registers");
    host_u.wr(8'h77, EMPTY_B);
    host_u.wr(8'h78, LEARN_B);
    host_u.wr(8'h79, 8'h0a);
    host_u.wr(8'h7a, 8'h51);
    host_u.wr(8'h7b, 8'h04);
    // Current under the dead band is not counted
    meas(16'h0ed8, 16'sh0004, 1'b1);
    pulses(1, 1'b1);
    chk(2'h1, 16'h0000);
    chk(2'h3, 16'h0001);
    host_u.wr(8'h7a, 8'h01);
    meas(16'h0ed8, 16'sh03e8, 1'b1);
    pulses(1024, 1'b1);
    nacExp = 16'h0400;
    chk(2'h1, nacExp);
    tdone("deadband");
    // Taper edges for every termination select
    for (int s = 0; s < 4; s++) begin
      termVoltSel <= 2'(s);
      meas(termMv[s] - 16'h0001, 16'sh0064, 1'b1);
      chk(2'h3, {14'h0000, s != 0, 1'b0});
      meas(termMv[s], 16'sh0080, 1'b1);
      chk(2'h3, {14'h0000, s != 0, 1'b0});
      meas(termMv[s], 16'sh0064, 1'b1);
      chk(2'h3, 16'h0012);
    end
    tdone("taper");
    meas(16'h0ed8, 16'sh03e8, 1'b1);
    sd_band(8'sh3c, 1800, 1'b1, 1'b0);
    sd_band(8'sh46, 1800, 1'b0, 1'b1);
    sd_band(8'sh3c, 1800, 1'b0, 1'b1);
    sd_band(8'sh37, 3600, 1'b0, 1'b1);
    sd_band(8'sh2d, 7200, 1'b0, 1'b1);
    sd_band(8'sh1e, 14400, 1'b0, 1'b1);
    sd_band(8'sh19, 28800, 1'b0, 1'b1);
    sd_band(8'sh0f, 28800, 1'b0, 1'b0);
    host_u.wr(8'h7a, 8'h00);
    // Below 10 C; code 0 keeps capacity still, the weight is still decoded
    tempC <= 8'shf6;
    tdone("self discharge");
    // Qualified discharge down to the learn threshold
    d = 30 + ($unsigned($random(seed)) % 150);
    meas(16'h0bb8, -16'sh0064, 1'b0);
    pulses(d, 1'b0);
    nacExp = nacExp - 16'(d);
    chk(2'h1, nacExp);
    meas(LEARN_MV, -16'sh0064, 1'b0);
    lmdExp = 16'(d) + 16'(d / 15);
    chk(2'h2, lmdExp);
    chk(2'h3, 16'h0008);
    // Current at twice the standby load disqualifies
    meas(termMv[3], 16'sh0064, 1'b1);
    meas(16'h0bb8, -16'sh0014, 1'b0);
    pulses(50, 1'b0);
    meas(LEARN_MV, -16'sh0014, 1'b0);
    chk(2'h2, lmdExp);
    chk(2'h3, 16'h0008);
    tdone("learning");
    nacExp = nacExp - 16'h0032;
    meas(EMPTY_MV + 16'h0001, -16'sh0014, 1'b0);
    chk(2'h1, nacExp);
    meas(EMPTY_MV, -16'sh0014, 1'b0);
    chk(2'h1, 16'h0000);
    chk(2'h3, 16'h000c);
    // Reset clears a standing taper flag
    meas(termMv[3], 16'sh0064, 1'b1);
    chk(2'h3, 16'h0012);
    srst <= 1'b1;
    step(2);
    chk(2'h3, 16'h0000);
    tdone("empty and reset");
    // Let the monitor take the last note before the run ends
    step(1);
    close_out();
  end
endmodule
`default_nettype wire
